// ---- pkg/ris_pkg.sv ----
// Constants, offsets and types of the remappable input select block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package ris_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  // Register byte offsets
  localparam logic [7:0]  OFF_LOCK = 8'h00;
  localparam logic [7:0]  OFF_SEL0 = 8'h04;
  localparam logic [7:0]  OFF_SEL1 = 8'h08;
  localparam logic [7:0]  OFF_SEL2 = 8'h0c;
  localparam logic [7:0]  OFF_SEL3 = 8'h10;
  localparam logic [7:0]  OFF_KEY  = 8'h14;
  // Lock field and unlock keys
  localparam int unsigned LOCK_BIT = 11;
  localparam logic        LOCK_RST = 1'b0;
  localparam logic [7:0]  KEY1     = 8'h55;
  localparam logic [7:0]  KEY2     = 8'haa;
  // Selection fields: 0 irq1, 1 irq2, 2 irq3, 3 timer clk, 4 capture1, 5 ccp1 clk
  localparam int unsigned NUM_SEL  = 6;
  localparam logic [7:0]  SEL_RST  = 8'h00;
  localparam logic [7:0]  SEL_OFF [NUM_SEL] = '{8'h04, 8'h08, 8'h08, 8'h0c, 8'h10, 8'h10};
  localparam logic        SEL_HI  [NUM_SEL] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // Unlock sequence states
  typedef enum logic [1:0] {
    RIS_UNL_IDLE  = 2'b00,
    RIS_UNL_KEY1  = 2'b01,
    RIS_UNL_ARMED = 2'b10
  } ris_unl_state_t;
endpackage

// ---- pkg/ris_unlock_if.sv ----
// Carrier between the register slave and the unlock sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ris_unlock_if;
  logic       key_wr;    // Accepted write to the key register
  logic       other_wr;  // Accepted write to any other address
  logic [7:0] key_data;  // Key byte written
  logic       armed;     // Next lock register write is allowed
  modport ctl (output key_wr, output other_wr, output key_data, input armed);
  modport unl (input key_wr, input other_wr, input key_data, output armed);
endinterface

// ---- logic/ris_pin_sync.sv ----
// Two-flop synchroniser for the remappable pin inputs.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ps
module ris_pin_sync #(
  parameter int unsigned WIDTH = 64
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins in, synchronised copy out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

  // Output follows the pins two edges later
  property p_sync_delay;
    @(posedge clock) disable iff (!rst_n)
      $past(rst_n, 1) && $past(rst_n, 2) |-> q == $past(d, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchroniser delay is not two cycles");
endmodule

// ---- logic/ris_unlock.sv ----
// Unlock sequencer: KEY1 then KEY2 on the key register arms one lock write.
// Assumes writes arrive one per cycle from the register slave.
`timescale 1ns/1ps
module ris_unlock (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Slave side
  ris_unlock_if.unl u
);
  ris_pkg::ris_unl_state_t state_reg;
  ris_pkg::ris_unl_state_t state_next;

  // Key sequence; any other write breaks or consumes it
  always_comb begin
    state_next = state_reg;
    if (u.other_wr) begin
      state_next = ris_pkg::RIS_UNL_IDLE;
    end else if (u.key_wr) begin
      case (state_reg)
        ris_pkg::RIS_UNL_KEY1: begin
          if (u.key_data == ris_pkg::KEY2) begin
            state_next = ris_pkg::RIS_UNL_ARMED;
          end else if (u.key_data == ris_pkg::KEY1) begin
            state_next = ris_pkg::RIS_UNL_KEY1;
          end else begin
            state_next = ris_pkg::RIS_UNL_IDLE;
          end
        end
        default: begin
          if (u.key_data == ris_pkg::KEY1) begin
            state_next = ris_pkg::RIS_UNL_KEY1;
          end else begin
            state_next = ris_pkg::RIS_UNL_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ris_pkg::RIS_UNL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign u.armed = (state_reg == ris_pkg::RIS_UNL_ARMED);

  // Arming only follows KEY2 written right after KEY1
  property p_arm_after_keys;
    @(posedge clock) disable iff (!rst_n)
      $rose(u.armed) |-> $past(u.key_wr) && $past(u.key_data) == ris_pkg::KEY2
                         && $past(state_reg) == ris_pkg::RIS_UNL_KEY1;
  endproperty
  a_arm_after_keys: assert property (p_arm_after_keys)
    else $error("Unlock armed without the key sequence");

  // Any non-key write leaves the sequencer disarmed
  property p_other_disarms;
    @(posedge clock) disable iff (!rst_n)
      u.other_wr |=> !u.armed;
  endproperty
  a_other_disarms: assert property (p_other_disarms)
    else $error("Unlock still armed after another write");
endmodule

// ---- logic/ris_top.sv ----
// Remappable input select: AXI4-Lite registers steer pins to peripheral inputs.
// Assumes pins are asynchronous and the bus master runs on clock.
`timescale 1ns/1ps
module ris_top #(
  parameter int unsigned NUM_PINS = 64
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // AXI4-Lite write address and data
  input  wire logic [ris_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [ris_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ris_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [ris_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Remappable pins, pin number n on bit n-1
  input  wire logic [NUM_PINS-1:0]        remappable_pin_n,
  // Peripheral inputs
  output logic                            ext_irq1,
  output logic                            ext_irq2,
  output logic                            ext_irq3,
  output logic                            gp_timer_ext_clk,
  output logic                            capture1_in,
  output logic                            ccp1_timer_clk
);
  localparam int unsigned NS = ris_pkg::NUM_SEL;

  // Select values are 8 bits, so at most 255 pins
  if (NUM_PINS < 1 || NUM_PINS > 255) begin : g_bad_pins
    $error("NUM_PINS must be 1 to 255");
  end

  ris_unlock_if u ();

  logic [7:0]                 sel_reg [NS];
  logic [NS-1:0]              out_reg;
  logic                       remap_lock;
  logic [NUM_PINS-1:0]        pin_sync;
  logic                       aw_full_reg;
  logic                       w_full_reg;
  logic [ris_pkg::ADDR_W-1:0] awaddr_reg;
  logic [ris_pkg::DATA_W-1:0] wdata_reg;
  logic [3:0]                 wstrb_reg;
  logic [ris_pkg::ADDR_W-1:0] rd_off_reg;

  // Pin synchroniser
  ris_pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (remappable_pin_n),
    .q     (pin_sync)
  );

  // Unlock sequencer
  ris_unlock u_unlock (
    .clock (clock),
    .rst_n (rst_n),
    .u     (u.unl)
  );

  // Write channel: address and data taken in either order
  wire                       aw_hs = s_axi_awvalid & s_axi_awready;
  wire                       w_hs  = s_axi_wvalid & s_axi_wready;
  wire                       aw_ok = aw_full_reg | aw_hs;
  wire                       w_ok  = w_full_reg | w_hs;
  wire                       do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  wire [ris_pkg::ADDR_W-1:0] wa    = aw_full_reg ? awaddr_reg : s_axi_awaddr;
  wire [ris_pkg::DATA_W-1:0] wd    = w_full_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]                 ws    = w_full_reg ? wstrb_reg : s_axi_wstrb;
  wire                       aw_full_next = aw_ok & ~do_wr;
  wire                       w_full_next  = w_ok & ~do_wr;
  wire                       bvalid_next  = do_wr | (s_axi_bvalid & ~s_axi_bready);

  // Write address decode
  wire wa_lock   = (wa == ris_pkg::OFF_LOCK);
  wire wa_key    = (wa == ris_pkg::OFF_KEY);
  wire wa_mapped = wa_lock | wa_key | (wa == ris_pkg::OFF_SEL0) | (wa == ris_pkg::OFF_SEL1)
                 | (wa == ris_pkg::OFF_SEL2) | (wa == ris_pkg::OFF_SEL3);
  wire lock_we   = do_wr & wa_lock & ws[1] & u.armed;

  // Unlock sequencer strobes
  assign u.key_wr   = do_wr & wa_key & ws[0];
  assign u.other_wr = do_wr & ~wa_key;
  assign u.key_data = wd[7:0];

  // Write channel registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ris_pkg::RESP_OKAY;
    end else begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready  <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (do_wr) begin
        s_axi_bresp <= wa_mapped ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
      end
    end
  end

  // Lock bit, cleared by reset, written only when armed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      remap_lock <= ris_pkg::LOCK_RST;
    end else if (lock_we) begin
      remap_lock <= wd[ris_pkg::LOCK_BIT];
    end
  end

  // Pins padded so a select value indexes directly; 0 and unused numbers read low
  wire [255:0] pin_ext = {{(255 - NUM_PINS){1'b0}}, pin_sync, 1'b0};

  // One selection field and one routed output per peripheral input
  for (genvar i = 0; i < NS; i++) begin : g_sel
    wire       hit  = (wa == ris_pkg::SEL_OFF[i]);
    wire       lane = ws[ris_pkg::SEL_HI[i] ? 1 : 0];
    wire       we   = do_wr & hit & lane & ~remap_lock;
    wire [7:0] byt  = ris_pkg::SEL_HI[i] ? wd[15:8] : wd[7:0];

    // Field register and output flop; outputs may share a pin
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        sel_reg[i] <= ris_pkg::SEL_RST;
        out_reg[i] <= 1'b0;
      end else begin
        if (we) begin
          sel_reg[i] <= byt;
        end
        out_reg[i] <= pin_ext[sel_reg[i]];
      end
    end
  end

  // Peripheral inputs in field order
  assign ext_irq1         = out_reg[0];
  assign ext_irq2         = out_reg[1];
  assign ext_irq3         = out_reg[2];
  assign gp_timer_ext_clk = out_reg[3];
  assign capture1_in      = out_reg[4];
  assign ccp1_timer_clk   = out_reg[5];

  // Read channel: one read at a time, answered the edge after it is taken
  wire                       ar_hs       = s_axi_arvalid & s_axi_arready;
  wire                       rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [ris_pkg::ADDR_W-1:0] ra          = s_axi_araddr;
  wire [15:0] lock_word = {4'h0, remap_lock, 11'h000};
  wire [15:0] sel0_word = {sel_reg[0], 8'h00};
  wire [15:0] sel1_word = {sel_reg[2], sel_reg[1]};
  wire [15:0] sel2_word = {sel_reg[3], 8'h00};
  wire [15:0] sel3_word = {sel_reg[4], sel_reg[5]};
  wire [15:0] key_word  = {15'h0000, u.armed};
  wire [15:0] rd_word   = (ra == ris_pkg::OFF_LOCK) ? lock_word
                        : (ra == ris_pkg::OFF_SEL0) ? sel0_word
                        : (ra == ris_pkg::OFF_SEL1) ? sel1_word
                        : (ra == ris_pkg::OFF_SEL2) ? sel2_word
                        : (ra == ris_pkg::OFF_SEL3) ? sel3_word
                        : key_word;
  wire ra_mapped = (ra == ris_pkg::OFF_LOCK) | (ra == ris_pkg::OFF_SEL0)
                 | (ra == ris_pkg::OFF_SEL1) | (ra == ris_pkg::OFF_SEL2)
                 | (ra == ris_pkg::OFF_SEL3) | (ra == ris_pkg::OFF_KEY);

  // Read channel registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ris_pkg::RESP_OKAY;
      rd_off_reg    <= '0;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_hs) begin
        rd_off_reg  <= ra;
        s_axi_rdata <= ra_mapped ? {16'h0000, rd_word} : '0;
        s_axi_rresp <= ra_mapped ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
      end
    end
  end

  // Locked: a write to the fourth select register leaves its capture1 and ccp1 fields unchanged
  property p_locked_hold;
    @(posedge clock) disable iff (!rst_n)
      do_wr && remap_lock && wa == ris_pkg::OFF_SEL3
        |=> $stable(sel_reg[4]) && $stable(sel_reg[5]);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("Select field changed while locked");

  // Unlocked: upper byte of the second select lands in the irq3 field
  property p_unlocked_write;
    @(posedge clock) disable iff (!rst_n)
      do_wr && !remap_lock && wa == ris_pkg::OFF_SEL1 && ws[1]
        |=> sel_reg[2] == $past(wd[15:8]);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write)
    else $error("Unlocked select write not stored");

  // Lock bit only changes through an armed lock write
  property p_lock_needs_unlock;
    @(posedge clock) disable iff (!rst_n)
      $changed(remap_lock) |-> $past(lock_we) && $past(u.armed);
  endproperty
  a_lock_needs_unlock: assert property (p_lock_needs_unlock)
    else $error("Lock bit changed without unlock");

  // Lock register reads zero outside the lock bit
  property p_lock_read_zero;
    @(posedge clock) disable iff (!rst_n)
      s_axi_rvalid && rd_off_reg == ris_pkg::OFF_LOCK
        |-> s_axi_rdata[31:12] == '0 && s_axi_rdata[10:0] == '0;
  endproperty
  a_lock_read_zero: assert property (p_lock_read_zero)
    else $error("Lock register unused bits not zero");

  // First select register low byte reads zero
  property p_sel0_low_zero;
    @(posedge clock) disable iff (!rst_n)
      s_axi_rvalid && rd_off_reg == ris_pkg::OFF_SEL0 |-> s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_sel0_low_zero: assert property (p_sel0_low_zero)
    else $error("First select low byte not zero");

  // Select value zero drives the timer clock low
  property p_zero_sel_low;
    @(posedge clock) disable iff (!rst_n)
      sel_reg[3] == 8'h00 |=> !gp_timer_ext_clk;
  endproperty
  a_zero_sel_low: assert property (p_zero_sel_low)
    else $error("Unassigned select did not give low");

  // Pin 1 reaches irq2 three edges after the pin
  property p_pin_latency;
    @(posedge clock) disable iff (!rst_n)
      (sel_reg[1] == 8'h01)[*4] |-> ext_irq2 == $past(remappable_pin_n[0], 3);
  endproperty
  a_pin_latency: assert property (p_pin_latency)
    else $error("Pin to irq2 latency wrong");

  // Two inputs on the same pin follow it together
  property p_shared_pin;
    @(posedge clock) disable iff (!rst_n)
      (sel_reg[0] == sel_reg[4])[*2] |-> ext_irq1 == capture1_in;
  endproperty
  a_shared_pin: assert property (p_shared_pin)
    else $error("Shared pin gave different inputs");
endmodule

// ---- tb/ris_pin_model.sv ----
// External pin drivers for the remappable input select block.
// Assumes the bench sets the wanted levels; pins settle away from the clock edge.
`timescale 1ns/1ps
module ris_pin_model #(
  parameter int unsigned NUM_PINS = 64
) (
  // Wanted levels from the bench
  input  wire logic [NUM_PINS-1:0] level,
  // Levels seen on the pins
  output logic      [NUM_PINS-1:0] pins
);
  // Pins are only ever inputs here; direction setup is software's job
  always_comb begin
    pins = level;
  end
endmodule

// ---- tb/test_remappable_input_select.sv ----
// Self-checking bench: AXI4-Lite register access, lock sequence and pin routing.
// Assumes ris_top answers per its hand-over contract; pins driven by ris_pin_model.
`timescale 1ns/1ps
module test_remappable_input_select;
  localparam int unsigned NP = 64;
  localparam logic [1:0] OK = ris_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ris_pkg::RESP_SLVERR;
  // Bench signals
  logic          clock;
  logic          rst_n;
  logic [7:0]    awaddr;
  logic [7:0]    araddr;
  logic          awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp;
  logic [1:0]    rresp;
  logic [NP-1:0] lvl;
  logic [NP-1:0] pins;
  logic          ext_irq1, ext_irq2, ext_irq3, gp_timer_ext_clk, capture1_in, ccp1_timer_clk;
  logic [5:0]    outs;
  int            n_mismatch;
  int            n_compared;

  // Peripheral inputs gathered, irq1 in bit 0
  assign outs = {ccp1_timer_clk, capture1_in, gp_timer_ext_clk, ext_irq3, ext_irq2, ext_irq1};

  ris_pin_model #(.NUM_PINS(NP)) pin_model (.level(lvl), .pins(pins));

  ris_top #(.NUM_PINS(NP)) dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remappable_pin_n(pins),
    .ext_irq1(ext_irq1), .ext_irq2(ext_irq2), .ext_irq3(ext_irq3),
    .gp_timer_ext_clk(gp_timer_ext_clk), .capture1_in(capture1_in),
    .ccp1_timer_clk(ccp1_timer_clk)
  );

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // AXI4-Lite write; handshakes sampled at the rising edge, released right after it
  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    logic       done;
    done = 1'b0;
    r = 2'b11;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // AXI4-Lite read with expected data and response, taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    logic        done;
    done = 1'b0;
    d = '1;
    r = 2'b11;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // Unlock sequence on the key register
  task automatic unlock();
    axi_wr(ris_pkg::OFF_KEY, {24'h0, ris_pkg::KEY1}, 4'h1, OK);
    axi_wr(ris_pkg::OFF_KEY, {24'h0, ris_pkg::KEY2}, 4'h1, OK);
  endtask

  // Drive pins, expect old outputs after two edges and new ones after three
  task automatic pins_chk(input logic [NP-1:0] v, input logic [5:0] eo, input logic [5:0] en);
    @(posedge clock);
    lvl <= v;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("outs_early", {26'h0, eo}, {26'h0, outs});
    @(negedge clock);
    chk("outs", {26'h0, en}, {26'h0, outs});
  endtask

  // Reset held for 10 cycles
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  // Test sequence
  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    lvl = '0;
    n_mismatch = 0;
    n_compared = 0;
    do_reset();
    for (int i = 0; i < 5; i++) axi_rd(8'(4 * i), 32'h0, OK);
    axi_wr(8'h04, 32'hffff_ffff, 4'hf, OK);
    axi_rd(8'h04, 32'h0000_ff00, OK);
    axi_wr(8'h0c, 32'hffff_ffff, 4'hf, OK);
    axi_rd(8'h0c, 32'h0000_ff00, OK);
    axi_wr(8'h00, 32'h0000_0800, 4'h3, OK);
    axi_rd(8'h00, 32'h0, OK);
    axi_wr(8'h18, 32'h0000_1234, 4'h3, ERR);
    axi_rd(8'h18, 32'h0, ERR);
    // One distinct pin per peripheral input
    axi_wr(8'h04, 32'h0000_0100, 4'h3, OK);
    axi_wr(8'h08, 32'h0000_0302, 4'h3, OK);
    axi_wr(8'h0c, 32'h0000_0400, 4'h3, OK);
    axi_wr(8'h10, 32'h0000_0506, 4'h3, OK);
    axi_rd(8'h08, 32'h0000_0302, OK);
    axi_rd(8'h10, 32'h0000_0506, OK);
    pins_chk('0, 6'h00, 6'h00);
    // Early value is the previous pin's output, one bit lower
    for (int k = 0; k < 6; k++) pins_chk(NP'(1) << k, (6'(1) << k) >> 1, 6'(1) << k);
    // Every input on the last pin
    axi_wr(8'h04, 32'h0000_4000, 4'h3, OK);
    axi_wr(8'h08, 32'h0000_4040, 4'h3, OK);
    axi_wr(8'h0c, 32'h0000_4000, 4'h3, OK);
    axi_wr(8'h10, 32'h0000_4040, 4'h3, OK);
    pins_chk(NP'(1) << (NP - 1), 6'h00, 6'h3f);
    // Out-of-range and zero selections stay low; irq2 moves to pin 1
    axi_wr(8'h04, 32'h0000_4100, 4'h3, OK);
    axi_wr(8'h08, 32'h0000_0001, 4'h3, OK);
    pins_chk('1, 6'h38, 6'h3a);
    // Lock after the unlock sequence
    unlock();
    axi_rd(ris_pkg::OFF_KEY, 32'h1, OK);
    axi_wr(8'h00, 32'hffff_ffff, 4'h3, OK);
    axi_rd(8'h00, 32'h0000_0800, OK);
    axi_wr(8'h10, 32'h0000_0101, 4'h3, OK);
    axi_rd(8'h10, 32'h0000_4040, OK);
    pins_chk('1, 6'h3a, 6'h3a);
    // A wrong second key leaves the lock register alone
    axi_wr(ris_pkg::OFF_KEY, {24'h0, ris_pkg::KEY1}, 4'h1, OK);
    axi_wr(ris_pkg::OFF_KEY, 32'h0000_0012, 4'h1, OK);
    axi_wr(8'h00, 32'h0, 4'h3, OK);
    axi_rd(8'h00, 32'h0000_0800, OK);
    // Clearing the lock opens the fields again
    unlock();
    axi_wr(8'h00, 32'h0, 4'h3, OK);
    axi_rd(8'h00, 32'h0, OK);
    axi_wr(8'h10, 32'h0000_0101, 4'h3, OK);
    axi_rd(8'h10, 32'h0000_0101, OK);
    axi_wr(8'h08, 32'h0000_aabb, 4'h2, OK);
    axi_rd(8'h08, 32'h0000_aa01, OK);
    // Locked, then reset in mid-run
    unlock();
    axi_wr(8'h00, 32'h0000_0800, 4'h3, OK);
    do_reset();
    axi_rd(8'h00, 32'h0, OK);
    axi_rd(8'h10, 32'h0, OK);
    @(negedge clock);
    chk("outs_reset", 32'h0, {26'h0, outs});
    summarize();
  end
endmodule
